// >>> hdl/rpm_ctrl.sv
// reset source gathering, boot vector selection and power mode sequencing, APB slave
`timescale 1ns/1ps
`include "rpm_defs.svh"
// Contract
// - brownout resets by default, option makes interrupt
// - brownout detect enable; off blocks reset, interrupt
// - power-on flag set at power-up, software clears
// - idle halts cpu, peripherals run, interrupt/reset exits
// - power-down stops oscillator; exit on reset/wake
// - power-down keeps brownout, watchdog, comparators, timer
// - rc oscillator stops unless system clock and timer
// - total power-down also disables brownout and comparators
// - pin enable bit selects reset or digital input
// - during power-up pin always acts as reset
// - only power-up reset overrides pin selection
// - reset from pin, por, bod, wdt, sw, break
// - one cause flag per source, set on reset
// - writing zero clears a cause flag
// - power-on sets power-on, brownout flags, clears others
// - other resets set own flag, keep others
// - boot address is vector byte then 00h
// - boot address on break, boot status, forced isp
module rpm_ctrl
   import rpm_pkg::*;
#(
   parameter int STABLE_CYC = `RPM_STABLE_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        shared_reset_pin,
   input  wire logic        power_on_det,
   input  wire logic        brownout_det,
   input  wire logic        wdt_timeout,
   input  wire logic        uart_break,
   input  wire logic        isp_forced,
   input  wire logic [7:0]  boot_status_byte,
   input  wire logic [7:0]  boot_vector,
   input  wire logic        irq_pending,
   input  wire logic        wake_irq,
   output logic             sys_reset,
   output logic             pin_digital_in,
   output logic             brownout_irq,
   output logic             cpu_clk_en,
   output logic             periph_clk_en,
   output logic             osc_en,
   output logic             rc_osc_en,
   output logic             bod_en,
   output logic             cmp_en,
   output logic             wdt_en,
   output logic             rtc_en,
   output logic [15:0]      fetch_addr
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   logic [4:0]  s1_q;
   logic [4:0]  s2_q;
   logic [5:0]  cause_q;
   logic [7:0]  cfg_q;
   logic [7:0]  boot_q;
   logic        isp_q;
   logic        por_phase_q;
   logic        brk_boot_q;
   logic [CW-1:0] hold_q;
   rpm_mode_t   mode_q;
   logic        sw_rst_q;
   logic        wr;
   logic        rd_ok;
   logic        pin_rst;
   logic        por;
   logic        bo_ev;
   logic        any_rst;
   logic [5:0]  ev;
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction
   // two flops per detector and the pin; stage one feeds stage two only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= 5'h01;
         s2_q <= 5'h01;
      end
      else
      begin
         s1_q <= {uart_break, wdt_timeout, brownout_det, ~shared_reset_pin, power_on_det};
         s2_q <= s1_q;
      end
   end
   assign por = s2_q[0];
   // pin acts as reset during power-up or when enabled
   assign pin_rst = s2_q[1] & (por_phase_q | cfg_q[`RPM_C_RPE]);
   assign pin_digital_in = ~por_phase_q & ~cfg_q[`RPM_C_RPE];
   assign bo_ev = s2_q[2] & cfg_q[`RPM_C_BOE] & (mode_q != RPM_TPD);
   assign ev = {s2_q[4], sw_rst_q, s2_q[3], bo_ev & ~cfg_q[`RPM_C_BOINT], por, pin_rst};
   assign any_rst = |ev;
   assign brownout_irq = bo_ev & cfg_q[`RPM_C_BOINT];
   assign wr = psel & penable & pwrite;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         por_phase_q <= 1'b1;
      else if (por)
         por_phase_q <= 1'b1;
      else if (hold_q == '0)
         por_phase_q <= 1'b0;
   end
   // reset stays asserted until the clock has run stable for the hold count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hold_q <= CW'(STABLE_CYC);
      else if (any_rst)
         hold_q <= CW'(STABLE_CYC);
      else if (hold_q != '0)
         hold_q <= hold_q - CW'(1);
   end
   assign sys_reset = any_rst | (hold_q != '0);
   // set wins over a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cause_q <= 6'h06;
      else if (por)
         cause_q <= 6'h06;
      else
         cause_q <= ((wr && hit(paddr, `RPM_CAUSE_OFF)) ? (cause_q & pwdata[5:0]) : cause_q)
                    | (ev & 6'h3d);
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_q <= `RPM_CFG_RST;
      else if (wr && hit(paddr, `RPM_CFG_OFF))
         cfg_q <= pwdata[7:0];
   end
   // software reset is a one-cycle request that clears itself
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sw_rst_q <= 1'b0;
      else
         sw_rst_q <= wr && hit(paddr, `RPM_CFG_OFF) && pwdata[`RPM_C_SWRST];
   end
   // isp strap is caught while power-up reset is in progress, not at the async edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         isp_q <= 1'b0;
      else if (por_phase_q)
         isp_q <= isp_forced;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         brk_boot_q <= 1'b0;
      else if (s2_q[4])
         brk_boot_q <= 1'b1;
      else if (ev != 6'h00)
         brk_boot_q <= 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         boot_q <= `RPM_BOOT_RST;
      else
         boot_q <= boot_vector;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fetch_addr <= 16'h0000;
      else if (brk_boot_q | boot_status_byte[0] | isp_q)
         fetch_addr <= {boot_q, 8'h00};
      else
         fetch_addr <= 16'h0000;
   end
   // mode sequencer: requests come from software, wake from irqs or reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= RPM_RUN;
      else if (any_rst)
         mode_q <= RPM_RUN;
      else
      begin
         case (mode_q)
            RPM_RUN:
            begin
               if (wr && hit(paddr, `RPM_PWR_OFF))
               begin
                  case (rpm_req_t'(pwdata[1:0]))
                     RPM_PWR_IDLE: mode_q <= RPM_IDLE;
                     RPM_PWR_PD:   mode_q <= RPM_PD;
                     RPM_PWR_TPD:  mode_q <= RPM_TPD;
                     default:      mode_q <= RPM_RUN;
                  endcase
               end
            end
            RPM_IDLE:
               if (irq_pending | brownout_irq)
                  mode_q <= RPM_RUN;
            RPM_PD,
            RPM_TPD:
               if (wake_irq | brownout_irq)
                  mode_q <= RPM_RUN;
            default:
               mode_q <= RPM_RUN;
         endcase
      end
   end
   // clock and domain enables per mode
   always_comb
   begin
      cpu_clk_en    = (mode_q == RPM_RUN);
      periph_clk_en = (mode_q == RPM_RUN) | (mode_q == RPM_IDLE);
      osc_en        = (mode_q == RPM_RUN) | (mode_q == RPM_IDLE);
      rc_osc_en     = osc_en | (cfg_q[`RPM_C_RCSYS] & cfg_q[`RPM_C_RTCEN]);
      bod_en        = cfg_q[`RPM_C_BOE] & (mode_q != RPM_TPD);
      cmp_en        = ~cfg_q[`RPM_C_CMPOFF] & (mode_q != RPM_TPD);
      wdt_en        = 1'b1;
      rtc_en        = cfg_q[`RPM_C_RTCEN];
   end
   // apb: zero wait states, unmapped reads zero with slverr
   assign rd_ok = hit(paddr, `RPM_CAUSE_OFF) | hit(paddr, `RPM_CFG_OFF) | hit(paddr, `RPM_PWR_OFF)
                | hit(paddr, `RPM_STAT_OFF) | hit(paddr, `RPM_BOOT_OFF);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~rd_ok;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel & ~penable & ~pwrite)
      begin
         if (hit(paddr, `RPM_CAUSE_OFF))
            prdata <= {26'h0, cause_q};
         else if (hit(paddr, `RPM_CFG_OFF))
            prdata <= {24'h0, cfg_q & 8'hbf};
         else if (hit(paddr, `RPM_PWR_OFF))
            prdata <= {28'h0, mode_q};
         else if (hit(paddr, `RPM_STAT_OFF))
            prdata <= {24'h0, pin_digital_in, por_phase_q, isp_q, brk_boot_q, bod_en, cmp_en, rc_osc_en, osc_en};
         else if (hit(paddr, `RPM_BOOT_OFF))
            prdata <= {16'h0, fetch_addr};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // cause flag checks
   chk_por_flags: assert property (@(posedge pclk) disable iff (!presetn)
      por |=> cause_q == 6'h06)
      else $error("power-on did not set exactly por and bo flags");

   chk_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (!por && s2_q[3]) |=> cause_q[`RPM_F_WDT] && ((($past(cause_q) & ~cause_q & 6'h37) == 6'h00) || $past(wr)))
      else $error("non-por reset lost a flag");

   chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      (!por && ev != 6'h00) |=> (cause_q & ($past(ev) & 6'h3d)) == ($past(ev) & 6'h3d))
      else $error("reset source did not set its flag");

   chk_por_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (cause_q[`RPM_F_POF] && !(wr && hit(paddr, `RPM_CAUSE_OFF) && !pwdata[`RPM_F_POF]))
      |=> cause_q[`RPM_F_POF])
      else $error("power-on flag lost without a clear");

   chk_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, `RPM_CAUSE_OFF) && ev == 6'h00 && !pwdata[0]) |=> !cause_q[0])
      else $error("write zero did not clear flag");

   chk_write_one: assert property (@(posedge pclk) disable iff (!presetn)
      (!por && wr && hit(paddr, `RPM_CAUSE_OFF) && pwdata[5:0] == 6'h3f)
      |=> cause_q == ($past(cause_q) | ($past(ev) & 6'h3d)))
      else $error("write one changed a flag");

   // reset source checks
   chk_sw_rst: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, `RPM_CFG_OFF) && pwdata[`RPM_C_SWRST]) |=> sys_reset)
      else $error("software reset request ignored");

   chk_bo_off: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg_q[`RPM_C_BOE] |-> !brownout_irq && !ev[`RPM_F_BOF])
      else $error("disabled brownout had effect");

   chk_bo_irq: assert property (@(posedge pclk) disable iff (!presetn)
      brownout_irq |-> !ev[`RPM_F_BOF] && cfg_q[`RPM_C_BOINT])
      else $error("brownout interrupt also reset");

   chk_bo_rst: assert property (@(posedge pclk) disable iff (!presetn)
      (s2_q[2] && cfg_q[`RPM_C_BOE] && !cfg_q[`RPM_C_BOINT] && mode_q != RPM_TPD)
      |-> sys_reset && !brownout_irq)
      else $error("enabled brownout did not reset");

   chk_tpd_bo: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == RPM_TPD && s2_q[2]) |-> !brownout_irq && !ev[`RPM_F_BOF])
      else $error("brownout acted in total power-down");

   chk_pin_sel: assert property (@(posedge pclk) disable iff (!presetn)
      (!por_phase_q && !cfg_q[`RPM_C_RPE]) |-> !pin_rst)
      else $error("pin reset while disabled");

   chk_pin_por: assert property (@(posedge pclk) disable iff (!presetn)
      (por_phase_q && s2_q[1]) |-> sys_reset)
      else $error("low pin did not hold power-up reset");

   chk_pin_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (!por && !por_phase_q) |=> !por_phase_q)
      else $error("non-power-up reset overrode pin selection");

   chk_por_phase: assert property (@(posedge pclk) disable iff (!presetn)
      por |=> por_phase_q)
      else $error("power-up did not force pin to reset");

   chk_rst_hold: assert property (@(posedge pclk) disable iff (!presetn)
      any_rst |=> sys_reset [*2])
      else $error("reset released too early");

   // power mode checks
   chk_idle_clk: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == RPM_IDLE |-> !cpu_clk_en && periph_clk_en)
      else $error("idle clocks wrong");

   chk_idle_exit: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == RPM_IDLE && irq_pending) |=> mode_q == RPM_RUN)
      else $error("interrupt did not end idle");

   chk_pd_osc: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == RPM_PD || mode_q == RPM_TPD) |-> !osc_en && !cpu_clk_en)
      else $error("oscillator runs in power-down");

   chk_pd_exit: assert property (@(posedge pclk) disable iff (!presetn)
      ((mode_q == RPM_PD || mode_q == RPM_TPD) && wake_irq) |=> mode_q == RPM_RUN)
      else $error("wake interrupt did not end power-down");

   chk_mode_rst: assert property (@(posedge pclk) disable iff (!presetn)
      any_rst |=> mode_q == RPM_RUN)
      else $error("reset did not end low-power mode");

   chk_pd_keep: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == RPM_PD
      |-> wdt_en && bod_en == cfg_q[`RPM_C_BOE] && cmp_en == !cfg_q[`RPM_C_CMPOFF] && rtc_en == cfg_q[`RPM_C_RTCEN])
      else $error("power-down stopped a kept block");

   chk_rc_osc: assert property (@(posedge pclk) disable iff (!presetn)
      !osc_en |-> rc_osc_en == (cfg_q[`RPM_C_RCSYS] && cfg_q[`RPM_C_RTCEN]))
      else $error("rc oscillator state wrong in power-down");

   chk_tpd_off: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == RPM_TPD |-> !bod_en && !cmp_en && !osc_en)
      else $error("total power-down left blocks on");

   // boot address checks; fetch_addr lags boot_q by one edge
   chk_boot_addr: assert property (@(posedge pclk) disable iff (!presetn)
      (boot_status_byte[0] && $stable(boot_status_byte)) |=> fetch_addr == {$past(boot_q), 8'h00})
      else $error("boot address wrong");

   chk_isp_boot: assert property (@(posedge pclk) disable iff (!presetn)
      isp_q |=> fetch_addr == {$past(boot_q), 8'h00})
      else $error("forced isp did not select boot address");

   chk_boot_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (!brk_boot_q && !boot_status_byte[0] && !isp_q) |=> fetch_addr == 16'h0000)
      else $error("fetch address not zero");

   chk_break_boot: assert property (@(posedge pclk) disable iff (!presetn)
      s2_q[4] |=> brk_boot_q)
      else $error("break reset did not mark boot");

   // main scenarios
   cov_idle_wake: cover property (@(posedge pclk) disable iff (!presetn) mode_q == RPM_IDLE ##1 mode_q == RPM_RUN);
   cov_pd_wake:   cover property (@(posedge pclk) disable iff (!presetn) mode_q == RPM_PD ##1 mode_q == RPM_RUN);
   cov_wdt_rst:   cover property (@(posedge pclk) disable iff (!presetn) ev[`RPM_F_WDT]);
   cov_break:     cover property (@(posedge pclk) disable iff (!presetn) brk_boot_q && !sys_reset);
   cov_pin_por:   cover property (@(posedge pclk) disable iff (!presetn) por_phase_q && pin_rst);
endmodule

// >>> hdl/rpm_defs.svh
// register offsets, field positions, reset values and timing counts for the reset/power controller
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH
`define RPM_CAUSE_OFF      12'h000
`define RPM_CFG_OFF        12'h004
`define RPM_PWR_OFF        12'h008
`define RPM_STAT_OFF       12'h00c
`define RPM_BOOT_OFF       12'h010
`define RPM_F_EXT          0
`define RPM_F_POF          1
`define RPM_F_BOF          2
`define RPM_F_WDT          3
`define RPM_F_SW           4
`define RPM_F_BRK          5
`define RPM_C_RPE          0
`define RPM_C_BOE          1
`define RPM_C_BOINT        2
`define RPM_C_RCSYS        3
`define RPM_C_RTCEN        4
`define RPM_C_CMPOFF       5
`define RPM_C_SWRST        6
`define RPM_CFG_RST        8'h02
`define RPM_BOOT_RST       8'h00
`define RPM_STABLE_NS      1000
`define RPM_CLK_NS         50
`define RPM_STABLE_CYC     ((`RPM_STABLE_NS + `RPM_CLK_NS - 1) / `RPM_CLK_NS)
`endif

// >>> hdl/rpm_pkg.sv
// types for the reset/power controller
package rpm_pkg;
   typedef enum logic [3:0]
   {
      RPM_RUN  = 4'b0001,
      RPM_IDLE = 4'b0010,
      RPM_PD   = 4'b0100,
      RPM_TPD  = 4'b1000
   } rpm_mode_t;
   typedef enum logic [1:0]
   {
      RPM_PWR_RUN  = 2'h0,
      RPM_PWR_IDLE = 2'h1,
      RPM_PWR_PD   = 2'h2,
      RPM_PWR_TPD  = 2'h3
   } rpm_req_t;
endpackage

// >>> verif/rpm_far_model.sv
// far side model: reset pin, supply detectors, watchdog and uart break
`timescale 1ns/1ps
module rpm_far_model
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] fire,
   output logic            shared_reset_pin,
   output logic            power_on_det,
   output logic            brownout_det,
   output logic            wdt_timeout,
   output logic            uart_break
);
   logic [3:0] act_q;
   logic [2:0] cnt_q;
   // events are held several cycles so a two-flop synchroniser cannot miss them
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         act_q        <= 4'h0;
         cnt_q        <= 3'h0;
         power_on_det <= 1'b1;
      end
      else
      begin
         power_on_det <= 1'b0;
         if (fire != 4'h0)
         begin
            act_q <= fire;
            cnt_q <= 3'h6;
         end
         else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
         else
            act_q <= 4'h0;
      end
   // pin idles high, pulled up; low means reset request
   assign shared_reset_pin = !act_q[0];
   assign brownout_det     = act_q[1];
   assign wdt_timeout      = act_q[2];
   assign uart_break       = act_q[3];
endmodule

// >>> verif/reset_power_mode_control_test.sv
// self-checking testbench for the reset and power mode controller
`timescale 1ns/1ps
`include "rpm_defs.svh"
module reset_power_mode_control_test;
   import rpm_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pin, por, bo, wdt, brk, irq_pending, wake_irq, sys_reset, pin_digital_in, brownout_irq, isp;
   logic        cpu_clk_en, periph_clk_en, osc_en, rc_osc_en, bod_en, cmp_en, wdt_en, rtc_en;
   logic [7:0]  boot_status_byte, boot_vector;
   logic [15:0] fetch_addr;
   logic [3:0]  fire;
   int          error_cnt, cmp_count;
   rpm_ctrl #(.STABLE_CYC(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shared_reset_pin(pin), .power_on_det(por), .brownout_det(bo), .wdt_timeout(wdt), .uart_break(brk),
      .isp_forced(isp), .boot_status_byte(boot_status_byte), .boot_vector(boot_vector),
      .irq_pending(irq_pending), .wake_irq(wake_irq), .sys_reset(sys_reset), .pin_digital_in(pin_digital_in),
      .brownout_irq(brownout_irq), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
      .rc_osc_en(rc_osc_en), .bod_en(bod_en), .cmp_en(cmp_en), .wdt_en(wdt_en), .rtc_en(rtc_en),
      .fetch_addr(fetch_addr));
   rpm_far_model far (.pclk(pclk), .presetn(presetn), .fire(fire), .shared_reset_pin(pin),
      .power_on_det(por), .brownout_det(bo), .wdt_timeout(wdt), .uart_break(brk));
   always #25 pclk = ~pclk;
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q        = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // let the write settle before callers look at outputs
      @(negedge pclk);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", e, q);
   endtask
   // fire an event (none: software reset write) and watch for a reset cycle
   task automatic hit(input logic [3:0] f, input logic ex, input logic ei);
      logic seen, irq;
      seen = 1'b0;
      irq  = 1'b0;
      if (f == 4'h0)
         apb(1'b1, `RPM_CFG_OFF, 32'h42);
      else
      begin
         @(posedge pclk);
         fire <= f;
         @(posedge pclk);
         fire <= 4'h0;
      end
      for (int n = 0; n < 40; n++)
      begin
         @(posedge pclk);
         seen = seen | (sys_reset === 1'b1);
         irq  = irq | (brownout_irq === 1'b1);
         if (seen && sys_reset === 1'b0)
            break;
      end
      chk("reset seen", {31'h0, ex}, {31'h0, seen});
      chk("bo irq", {31'h0, ei}, {31'h0, irq});
   endtask
   task automatic t_reset();
      rchk(`RPM_CAUSE_OFF, 32'h06);
      rchk(`RPM_CFG_OFF, 32'h02);
      rchk(`RPM_PWR_OFF, 32'h01);
      chk("fetch", 32'h0, {16'h0, fetch_addr});
      rchk(12'h020, 32'h0);
      chk("slverr", 32'h1, {31'h0, last_err});
   endtask
   task automatic t_flags();
      apb(1'b1, `RPM_CAUSE_OFF, 32'hff);
      rchk(`RPM_CAUSE_OFF, 32'h06);
      apb(1'b1, `RPM_CAUSE_OFF, 32'h04);
      rchk(`RPM_CAUSE_OFF, 32'h04);
   endtask
   task automatic t_sources();
      hit(4'h4, 1'b1, 1'b0);
      rchk(`RPM_CAUSE_OFF, 32'h0c);
      hit(4'h0, 1'b1, 1'b0);
      rchk(`RPM_CAUSE_OFF, 32'h1c);
      apb(1'b1, `RPM_CFG_OFF, 32'h02);
      chk("pin input", 32'h1, {31'h0, pin_digital_in});
      hit(4'h1, 1'b0, 1'b0);
      apb(1'b1, `RPM_CFG_OFF, 32'h03);
      chk("pin input", 32'h0, {31'h0, pin_digital_in});
      hit(4'h1, 1'b1, 1'b0);
      rchk(`RPM_CAUSE_OFF, 32'h1d);
   endtask
   task automatic t_brownout();
      apb(1'b1, `RPM_CAUSE_OFF, 32'h0);
      apb(1'b1, `RPM_CFG_OFF, 32'h02);
      hit(4'h2, 1'b1, 1'b0);
      rchk(`RPM_CAUSE_OFF, 32'h04);
      apb(1'b1, `RPM_CFG_OFF, 32'h06);
      hit(4'h2, 1'b0, 1'b1);
      apb(1'b1, `RPM_CFG_OFF, 32'h00);
      hit(4'h2, 1'b0, 1'b0);
   endtask
   task automatic t_boot();
      boot_vector <= 8'h5a;
      hit(4'h8, 1'b1, 1'b0);
      chk("fetch", 32'h5a00, {16'h0, fetch_addr});
      rchk(`RPM_BOOT_OFF, 32'h5a00);
      rchk(`RPM_CAUSE_OFF, 32'h24);
      hit(4'h4, 1'b1, 1'b0);
      chk("fetch", 32'h0, {16'h0, fetch_addr});
      boot_status_byte <= 8'h01;
      hit(4'h4, 1'b1, 1'b0);
      chk("fetch", 32'h5a00, {16'h0, fetch_addr});
      boot_status_byte <= 8'h00;
   endtask
   task automatic wake(input logic w);
      @(posedge pclk);
      irq_pending <= !w;
      wake_irq    <= w;
      repeat (4) @(posedge pclk);
      irq_pending <= 1'b0;
      wake_irq    <= 1'b0;
      rchk(`RPM_PWR_OFF, 32'h01);
   endtask
   task automatic t_power();
      apb(1'b1, `RPM_CFG_OFF, 32'h12);
      apb(1'b1, `RPM_PWR_OFF, 32'h1);
      chk("idle clk", 32'h1, {30'h0, cpu_clk_en, periph_clk_en});
      wake(1'b0);
      apb(1'b1, `RPM_PWR_OFF, 32'h2);
      chk("pd en", 32'h1e, {26'h0, osc_en, bod_en, wdt_en, cmp_en, rtc_en, rc_osc_en});
      wake(1'b1);
      apb(1'b1, `RPM_CFG_OFF, 32'h1a);
      apb(1'b1, `RPM_PWR_OFF, 32'h3);
      chk("tpd en", 32'h0b, {26'h0, osc_en, bod_en, wdt_en, cmp_en, rtc_en, rc_osc_en});
      hit(4'h2, 1'b0, 1'b0);
      hit(4'h4, 1'b1, 1'b0);
      rchk(`RPM_PWR_OFF, 32'h01);
   endtask
   // second power-up with isp strap forced and the pin held low while power-up runs
   task automatic t_isp();
      @(posedge pclk);
      isp     <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      fire    <= 4'h1;
      @(posedge pclk);
      fire    <= 4'h0;
      repeat (16) @(posedge pclk);
      chk("fetch", 32'h5a00, {16'h0, fetch_addr});
      rchk(`RPM_CAUSE_OFF, 32'h07);
      rchk(`RPM_STAT_OFF, 32'haf);
   endtask
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {fire, irq_pending, wake_irq, isp, boot_status_byte, boot_vector, error_cnt, cmp_count} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      t_reset();
      t_flags();
      t_sources();
      t_brownout();
      t_boot();
      t_power();
      t_isp();
      test_done();
   end
   initial
   begin
      #1000000;
      error_cnt++;
      test_done();
   end
endmodule
